/* src/reset_seq_pkg.sv */
package reset_seq_pkg;

	// ------------------------------------------------------------
	// clock and internal rc time base
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int RC_TICK_NS = 1000;
	localparam int RC_TICK_CYCLES = RC_TICK_NS / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 8;

	// ------------------------------------------------------------
	// power-up delay timer
	// ------------------------------------------------------------
	localparam int POWER_UP_DELAY_PERIOD_MS = 72;
	localparam int DELAY_TICKS_DEF =
		POWER_UP_DELAY_PERIOD_MS * 1000000 / RC_TICK_NS;
	localparam int DELAY_CNT_W = 17;

	// ------------------------------------------------------------
	// supply dip qualification
	// ------------------------------------------------------------
	localparam int DIP_MIN_DURATION_US = 100;
	localparam int DIP_MIN_TICKS =
		(DIP_MIN_DURATION_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
	localparam int DIP_CNT_W = 7;

	// ------------------------------------------------------------
	// oscillator start-up counter
	// ------------------------------------------------------------
	localparam int OSC_STARTUP_CYCLES = 1024;
	localparam int OSC_CNT_W = 10;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		OSC_RC,
		CRYSTAL_LOW_POWER_MODE,
		CRYSTAL_MID_MODE,
		CRYSTAL_HIGH_SPEED_MODE
	} oscMode_type;

	typedef struct packed {
		logic delayTimerFuse;
		logic dipResetEnableFuse;
		oscMode_type oscMode;
	} fuses_type;

	typedef struct packed {
		logic coreReset;
		logic wakeStall;
	} seqOut_type;

	localparam seqOut_type SEQ_OUT_RESET = '{coreReset: 1'b1,
		wakeStall: 1'b0};

endpackage

/* src/rc_tick_divider.sv */
`timescale 1ns/100ps
`default_nettype none
module rc_tick_divider
(
	input wire logic clk,
	input wire logic sys_rst,
	output logic tick
);
	import reset_seq_pkg::*;

	localparam logic [TICK_CNT_W-1:0] TICK_LAST =
		TICK_CNT_W'(RC_TICK_CYCLES - 1);

	logic [TICK_CNT_W-1:0] divCnt_q;

	// ------------------------------------------------------------
	// free-running rc time base
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			divCnt_q <= '0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (divCnt_q == TICK_LAST);
			if (divCnt_q == TICK_LAST)
				divCnt_q <= '0;
			else
				divCnt_q <= divCnt_q + 1'b1;
		end
	end

endmodule
`default_nettype wire

/* src/dip_qualifier.sv */
`timescale 1ns/100ps
`default_nettype none
module dip_qualifier
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic dipDetect,
	input wire logic tick,
	output logic belowLevel,
	output logic dipQualified
);
	import reset_seq_pkg::*;

	localparam logic [DIP_CNT_W-1:0] DIP_LAST =
		DIP_CNT_W'(DIP_MIN_TICKS - 1);

	logic dipS1_q;
	logic [DIP_CNT_W-1:0] dipCnt_q;

	// ------------------------------------------------------------
	// synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dipS1_q <= 1'b0;
			belowLevel <= 1'b0;
		end
		else
		begin
			dipS1_q <= dipDetect;
			belowLevel <= dipS1_q;
		end
	end

	// ------------------------------------------------------------
	// short dip filter
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			dipCnt_q <= '0;
			dipQualified <= 1'b0;
		end
		else if (!belowLevel)
		begin
			dipCnt_q <= '0;
			dipQualified <= 1'b0;
		end
		else if (tick && !dipQualified)
		begin
			if (dipCnt_q == DIP_LAST)
				dipQualified <= 1'b1;
			else
				dipCnt_q <= dipCnt_q + 1'b1;
		end
	end

endmodule
`default_nettype wire

/* src/power_up_reset_sequencer.sv */
// Summary of operation
// - supply-rise pulse starts the reset sequence
// - power-up delay timer runs its time-out; core held in reset meanwhile
// - delay timer counts rc ticks, independent of main oscillator
// - delay timer fuse clear skips the delay
// - after the delay, count 1024 main oscillator edges before release
// - start-up count only in crystal modes, only on power-on or wake
// - dip reset enable fuse gates the dip detector's reset effect
// - dips shorter than about 100 us are filtered out
// - after a qualified dip, hold reset until supply back above threshold
// - on recovery from a dip, run the full 72 ms delay
// - dip during the delay clears timer and restarts the sequence
// - dip reset enabled forces the delay timer on
// - rc mode wake from sleep inserts no start-up count
`timescale 1ns/100ps
`default_nettype none
module power_up_reset_sequencer
#(
	parameter int unsigned DELAY_TICKS = reset_seq_pkg::DELAY_TICKS_DEF
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic supplyRise,
	input wire logic dipDetect,
	input wire logic mainOscInput,
	input wire logic wakeReq,
	input wire reset_seq_pkg::fuses_type fuses,
	output reset_seq_pkg::seqOut_type seqOut
);
	import reset_seq_pkg::*;

	localparam logic [DELAY_CNT_W-1:0] DELAY_LAST =
		DELAY_CNT_W'(DELAY_TICKS - 1);
	localparam logic [OSC_CNT_W-1:0] OSC_LAST =
		OSC_CNT_W'(OSC_STARTUP_CYCLES - 1);

	typedef enum logic [2:0] {
		ST_HOLD,
		ST_DELAY,
		ST_OSC,
		ST_RUN,
		ST_WAKE
	} state_type;

	state_type stateQ;
	state_type stateD;
	logic [2:0] porS_q;
	logic [2:0] oscS_q;
	logic porEdge;
	logic oscEdge;
	logic tick;
	logic belowLevel;
	logic dipQualified;
	logic dipHit;
	logic crystal;
	logic useTimer;
	logic startupNeeded;
	logic porSeq_q;
	logic [DELAY_CNT_W-1:0] timerCnt_q;
	logic [OSC_CNT_W-1:0] oscCnt_q;
	seqOut_type seqOut_q;

	// ------------------------------------------------------------
	// sub-blocks
	// ------------------------------------------------------------
	rc_tick_divider rcTick
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.tick(tick)
	);

	dip_qualifier dipFilter
	(
		.clk(clk),
		.sys_rst(sys_rst),
		.dipDetect(dipDetect),
		.tick(tick),
		.belowLevel(belowLevel),
		.dipQualified(dipQualified)
	);

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			porS_q <= '0;
			oscS_q <= '0;
		end
		else
		begin
			porS_q <= {porS_q[1:0], supplyRise};
			oscS_q <= {oscS_q[1:0], mainOscInput};
		end
	end

	assign porEdge = porS_q[1] & ~porS_q[2];
	assign oscEdge = oscS_q[1] & ~oscS_q[2];
	assign dipHit = fuses.dipResetEnableFuse & dipQualified;
	assign crystal = (fuses.oscMode != OSC_RC);
	assign useTimer = fuses.delayTimerFuse | fuses.dipResetEnableFuse;
	assign startupNeeded = crystal & porSeq_q;

	// ------------------------------------------------------------
	// sequence state
	// ------------------------------------------------------------
	always_comb
	begin
		stateD = stateQ;
		unique case (stateQ)
			ST_HOLD:
			begin
				if (!(fuses.dipResetEnableFuse && belowLevel))
				begin
					if (useTimer)
						stateD = ST_DELAY;
					else if (startupNeeded)
						stateD = ST_OSC;
					else
						stateD = ST_RUN;
				end
			end
			ST_DELAY:
			begin
				if (tick && timerCnt_q == DELAY_LAST)
					stateD = startupNeeded ? ST_OSC : ST_RUN;
			end
			ST_OSC:
			begin
				if (oscEdge && oscCnt_q == OSC_LAST)
					stateD = ST_RUN;
			end
			ST_RUN:
			begin
				if (wakeReq && crystal)
					stateD = ST_WAKE;
			end
			ST_WAKE:
			begin
				if (oscEdge && oscCnt_q == OSC_LAST)
					stateD = ST_RUN;
			end
		endcase
		if (dipHit)
			stateD = ST_HOLD;
		if (porEdge)
			stateD = ST_HOLD;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			stateQ <= ST_HOLD;
		else
			stateQ <= stateD;
	end

	// power-on origin decides the start-up count
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			porSeq_q <= 1'b1;
		else if (porEdge)
			porSeq_q <= 1'b1;
		else if (dipHit)
			porSeq_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// counters
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			timerCnt_q <= '0;
		else if (stateQ != ST_DELAY || stateD != ST_DELAY)
			timerCnt_q <= '0;
		else if (tick)
			timerCnt_q <= timerCnt_q + 1'b1;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			oscCnt_q <= '0;
		else if (stateQ != stateD)
			oscCnt_q <= '0;
		else if (oscEdge && (stateQ == ST_OSC || stateQ == ST_WAKE))
			oscCnt_q <= oscCnt_q + 1'b1;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			seqOut_q <= SEQ_OUT_RESET;
		else
		begin
			seqOut_q.coreReset <= (stateD == ST_HOLD) ||
				(stateD == ST_DELAY) || (stateD == ST_OSC);
			seqOut_q.wakeStall <= (stateD == ST_WAKE);
		end
	end

	assign seqOut = seqOut_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_por_enters_hold: assert property (
		porEdge |=> stateQ == ST_HOLD && seqOut_q.coreReset)
		else $error("supply rise did not start the sequence");

	a_delay_holds_reset: assert property (
		stateQ == ST_DELAY |-> seqOut_q.coreReset)
		else $error("core left reset during power-up delay");

	a_delay_on_ticks: assert property (
		stateQ == ST_DELAY && stateD == ST_DELAY && !tick
		|=> $stable(timerCnt_q))
		else $error("delay timer moved without an rc tick");

	a_delay_skipped: assert property (
		stateQ == ST_HOLD && !useTimer && !porEdge && !dipHit
		|=> stateQ != ST_DELAY)
		else $error("delay ran with its fuse clear");

	a_startup_count: assert property (
		stateQ == ST_OSC && stateD == ST_RUN
		|-> oscEdge && oscCnt_q == OSC_LAST)
		else $error("start-up count ended early");

	a_startup_crystal: assert property (
		stateQ != ST_OSC && stateD == ST_OSC |-> crystal && porSeq_q)
		else $error("start-up count without crystal power-on");

	a_dip_gated: assert property (
		!fuses.dipResetEnableFuse && stateQ == ST_RUN && !porEdge
		&& !wakeReq |=> stateQ == ST_RUN)
		else $error("dip reset acted while disabled");

	a_dip_hold: assert property (
		stateQ == ST_HOLD && fuses.dipResetEnableFuse && belowLevel
		|=> stateQ == ST_HOLD && seqOut_q.coreReset)
		else $error("reset released while supply low");

	a_dip_full_delay: assert property (
		stateQ == ST_HOLD && stateD == ST_DELAY
		|=> stateQ == ST_DELAY && timerCnt_q == '0)
		else $error("delay did not start from zero");

	a_dip_restart: assert property (
		stateQ == ST_DELAY && dipHit
		|=> stateQ == ST_HOLD && timerCnt_q == '0)
		else $error("dip during delay did not restart");

	a_forced_timer: assert property (
		fuses.dipResetEnableFuse && stateQ == ST_HOLD && stateD != ST_HOLD
		|-> stateD == ST_DELAY)
		else $error("delay not forced with dip reset on");

	a_release_order: assert property (
		$fell(seqOut_q.coreReset) |-> stateQ == ST_RUN
		&& ($past(stateQ) == ST_OSC || $past(stateQ) == ST_DELAY
		|| $past(stateQ) == ST_HOLD))
		else $error("reset released out of order");

	a_rc_wake: assert property (
		stateQ == ST_RUN && wakeReq && !crystal && !porEdge && !dipHit
		|=> stateQ == ST_RUN ##1 !seqOut_q.wakeStall)
		else $error("rc wake inserted a start-up count");

	a_dip_filtered: assert property (
		stateQ == ST_RUN && !dipQualified && !porEdge && !wakeReq
		|=> stateQ == ST_RUN)
		else $error("unqualified dip reset the core");

	a_wake_stall_shown: assert property (
		stateQ == ST_WAKE |-> seqOut_q.wakeStall && !seqOut_q.coreReset)
		else $error("wake stall not shown during start-up count");

	a_osc_on_edges: assert property (
		(stateQ == ST_OSC || stateQ == ST_WAKE) && stateD == stateQ
		&& !oscEdge |=> $stable(oscCnt_q))
		else $error("start-up counter moved without an osc edge");

	c_dip_hold: cover property (
		stateQ == ST_HOLD && dipHit);
	c_rc_wake: cover property (
		stateQ == ST_RUN && wakeReq && !crystal);
	c_full_power_up: cover property (
		stateQ == ST_OSC ##1 stateQ == ST_RUN);
	c_dip_restart: cover property (
		stateQ == ST_DELAY && dipHit);
	c_wake_count: cover property (
		stateQ == ST_WAKE ##1 stateQ == ST_RUN);

endmodule
`default_nettype wire

/* tb/supply_osc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module supply_osc_model
(
	input wire logic clk,
	input wire logic porCmd,
	input wire logic dipCmd,
	output logic supplyRise,
	output logic dipDetect,
	output logic mainOscInput
);
	logic [1:0] oscCnt_q = 2'h0;
	logic [1:0] porCnt_q = 2'h0;
	logic osc_q = 1'b0;
	// ------------------------------------------------------------
	// crystal, 3 clk high and 3 clk low, runs free
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		oscCnt_q <= (oscCnt_q == 2'h2) ? 2'h0 : oscCnt_q + 2'h1;
		if (oscCnt_q == 2'h2)
			osc_q <= ~osc_q;
	end
	// ------------------------------------------------------------
	// supply-rise pulse, stretched to 4 clk
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (porCmd)
			porCnt_q <= 2'h3;
		else if (porCnt_q != 2'h0)
			porCnt_q <= porCnt_q - 2'h1;
	end
	assign supplyRise = porCmd | (porCnt_q != 2'h0);
	assign dipDetect = dipCmd;
	assign mainOscInput = osc_q;
endmodule
`default_nettype wire

/* tb/test_power_up_reset_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module test_power_up_reset_sequencer;
	import reset_seq_pkg::*;
	localparam int DT = 4;
	localparam int DLY = DT * RC_TICK_CYCLES;
	localparam int OSC = OSC_STARTUP_CYCLES * 6;
	typedef struct {fuses_type f; int exp;} row_type;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic porCmd = 1'b0;
	logic dipCmd = 1'b0;
	logic wakeReq = 1'b0;
	fuses_type fuses = '{1'b1, 1'b0, OSC_RC};
	logic supplyRise, dipDetect, mainOscInput;
	seqOut_type seqOut;
	int bad_count = 0;
	int compares = 0;
	int n;
	row_type rows [5];
	power_up_reset_sequencer #(.DELAY_TICKS(DT)) power_up_reset_sequencer_i
	(
		.clk(clk), .sys_rst(sys_rst), .supplyRise(supplyRise),
		.dipDetect(dipDetect), .mainOscInput(mainOscInput),
		.wakeReq(wakeReq), .fuses(fuses), .seqOut(seqOut)
	);
	supply_osc_model supply_osc_model_i
	(
		.clk(clk), .porCmd(porCmd), .dipCmd(dipCmd),
		.supplyRise(supplyRise), .dipDetect(dipDetect),
		.mainOscInput(mainOscInput)
	);
	initial
		forever #2 clk = ~clk;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task near(input string name, input int c, input int exp);
		check(name, 32'(c > exp - 300 && c < exp + 300), 32'h1);
	endtask
	task give_verdict;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task waitRst(input logic lvl, input int lim);
		n = 0;
		while (seqOut.coreReset !== lvl && n < lim)
		begin
			step(1);
			n++;
		end
	endtask
	task runSeq(input int exp);
		porCmd = 1'b1;
		step(1);
		porCmd = 1'b0;
		waitRst(1'b1, 20);
		check("reset rise", seqOut.coreReset, 32'h1);
		waitRst(1'b0, exp + 400);
		near("release time", n, exp);
	endtask
	task wake(input int exp);
		wakeReq = 1'b1;
		step(1);
		wakeReq = 1'b0;
		step(2);
		check("stall", seqOut.wakeStall, 32'(exp != 0));
		n = 0;
		while (seqOut.wakeStall === 1'b1 && n < OSC + 400)
		begin
			step(1);
			n++;
		end
		near("stall time", n, exp);
	endtask
	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	initial
	begin
		step(99000);
		bad_count++;
		$display("watchdog expired");
		give_verdict;
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		rows[0] = '{'{1'b1, 1'b0, OSC_RC}, DLY};
		rows[1] = '{'{1'b1, 1'b0, CRYSTAL_LOW_POWER_MODE}, DLY + OSC};
		rows[2] = '{'{1'b1, 1'b0, CRYSTAL_HIGH_SPEED_MODE}, DLY + OSC};
		rows[3] = '{'{1'b0, 1'b0, CRYSTAL_MID_MODE}, OSC};
		rows[4] = '{'{1'b0, 1'b1, OSC_RC}, DLY};
		repeat (5) @(posedge clk);
		check("reset value", seqOut, 32'(SEQ_OUT_RESET));
		#1 sys_rst = 1'b0;
		waitRst(1'b0, DLY + 400);
		for (int i = 0; i < 5; i++)
		begin
			fuses = rows[i].f;
			step(2);
			runSeq(rows[i].exp);
			$display("row %0d done", i);
		end
		fuses.oscMode = CRYSTAL_MID_MODE;
		wake(OSC);
		fuses.oscMode = OSC_RC;
		wake(0);
		$display("wake done");
		fuses = '{1'b0, 1'b1, CRYSTAL_MID_MODE};
		dipCmd = 1'b1;
		step(5000);
		dipCmd = 1'b0;
		step(200);
		check("short dip", seqOut.coreReset, 32'h0);
		dipCmd = 1'b1;
		waitRst(1'b1, 26000);
		check("dip reset", seqOut.coreReset, 32'h1);
		step(500);
		check("dip hold", seqOut.coreReset, 32'h1);
		dipCmd = 1'b0;
		waitRst(1'b0, DLY + 400);
		near("dip release", n, DLY);
		$display("dip done");
		fuses = '{1'b1, 1'b0, CRYSTAL_MID_MODE};
		dipCmd = 1'b1;
		step(26000);
		check("dip gated", seqOut.coreReset, 32'h0);
		dipCmd = 1'b0;
		$display("gate done");
		step(4);
		sys_rst = 1'b1;
		step(2);
		check("mid-run reset", seqOut, 32'(SEQ_OUT_RESET));
		sys_rst = 1'b0;
		waitRst(1'b0, DLY + OSC + 400);
		near("reset release", n, DLY + OSC);
		$display("reset done");
		give_verdict;
	end
endmodule
`default_nettype wire
